/* File: emit_pkg.sv */
// package: register map, reset values, field positions and phase codes of the memory port timing
`default_nettype none
package emit_pkg;
    // ****************************************************************
    // register addresses on the special-register port
    // ****************************************************************
    localparam logic [7:0] EMIT_PAGE_ADDR  = 8'hAA;   // external_data_space_page_reg
    localparam logic [7:0] EMIT_CFG_ADDR   = 8'hAB;   // ext_mem_config_reg
    localparam logic [7:0] EMIT_TMG_ADDR   = 8'hAF;   // ext_mem_timing_reg
    // reset values
    localparam logic [7:0] EMIT_PAGE_RST   = 8'h00;
    localparam logic [7:0] EMIT_CFG_RST    = 8'h03;   // internal-only, widest latch pulse
    localparam logic [7:0] EMIT_TMG_RST    = 8'hFF;   // longest setup, strobe, hold
    // writable masks: unused upper bits stay zero
    localparam logic [7:0] EMIT_PAGE_MASK  = 8'h1F;
    localparam logic [7:0] EMIT_CFG_MASK   = 8'h0F;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int EMIT_PAGE_OFF_BIT  = 4;            // page top bit: off-chip in split modes
    localparam int EMIT_MODE_LSB      = 2;            // operating_mode_select [3:2]
    localparam int EMIT_ALE_LSB       = 0;            // latch_pulse_width [1:0]
    localparam int EMIT_EAS_LSB       = 6;            // addr_setup_select [7:6]
    localparam int EMIT_EWR_LSB       = 2;            // strobe_width_select [5:2]
    localparam int EMIT_EAH_LSB       = 0;            // addr_hold_select [1:0]
    // fixed overhead of every off-chip move
    localparam logic [4:0] EMIT_OVHD_CYC  = 5'h04;
    // first address served off-chip in split modes (size of on-chip space)
    localparam logic [15:0] EMIT_ONCHIP_TOP = 16'h1000;
    // ****************************************************************
    // enumerations and carriers
    // ****************************************************************
    typedef enum logic [1:0] {
        EMIT_MODE_INT   = 2'b00,                      // internal only
        EMIT_MODE_SPLIT = 2'b01,                      // split, no bank select
        EMIT_MODE_BANK  = 2'b10,                      // split, bank select
        EMIT_MODE_EXT   = 2'b11                       // external only
    } emit_mode_e;
    typedef enum logic [2:0] {
        EMIT_IDLE   = 3'b000,
        EMIT_ALE_HI = 3'b001,
        EMIT_ALE_LO = 3'b010,
        EMIT_SETUP  = 3'b011,
        EMIT_STROBE = 3'b100,
        EMIT_HOLD   = 3'b101,
        EMIT_OVHD   = 3'b110
    } emit_phase_e;
    // one move request from the core
    typedef struct packed {
        logic        wr;                              // 1 write, 0 read
        logic        is8;                             // 8-bit move (page + low byte)
        logic [15:0] addr;                            // 16-bit address, low byte for 8-bit
        logic [7:0]  wdata;                           // write data
    } emit_req_s;
    // external pin group
    typedef struct packed {
        logic [11:0] addr;                            // address bus
        logic        addr_hi_oe;                      // drive addr[11:8]
        logic        addr_lo_oe;                      // drive addr[7:0]
        logic [7:0]  ad;                              // shared address/data out
        logic        ad_oe;                           // drive shared bus
        logic        ale;                             // address latch enable, high active
        logic        rd_n;                            // read strobe, low active
        logic        wr_n;                            // write strobe, low active
    } emit_pins_s;
endpackage
`default_nettype wire

/* File: emit_phase_cnt.sv */
// phase length down-counter for the memory port sequencer
`default_nettype none
module emit_phase_cnt (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // load a new phase length minus one
    input  wire logic       load_i,
    input  wire logic [4:0] load_val_i,
    // current phase reaches its last cycle
    output logic            last_o
);
    typedef struct packed {
        logic [4:0] cnt;                              // cycles left in phase
    } emit_cnt_s;

    emit_cnt_s cur;
    emit_cnt_s next_cur;

    // ****************************************************************
    // counting
    // ****************************************************************
    // load wins over counting so back-to-back phases never lose a cycle
    always_comb begin
        next_cur = cur;
        if (load_i) begin
            next_cur.cnt = load_val_i;
        end else if (cur.cnt != 5'h00) begin
            next_cur.cnt = cur.cnt - 5'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign last_o = (cur.cnt == 5'h00);

    // counter never climbs without a load
    cnt_down_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !$past(load_i) && !$past(sys_rst_i) |-> cur.cnt <= $past(cur.cnt))
        else $error("phase counter rose without load");
endmodule
`default_nettype wire

/* File: emit_timing.sv */
// external memory port: page/config/timing registers and strobe sequencer
`default_nettype none
// Function
// - setup, strobe, hold, latch widths programmable in cycles
// - access lasts programmed sum plus four cycles
// - multiplexed latch adds at least two cycles
// - setup and hold reset to longest values
// - 8-bit move takes high byte from page
// - page bits 7:5 read zero, ignore writes
// - page top bit sends split-mode 8-bit moves off-chip
// - mode field selects internal/split/bank/external
// - latch high and low last field plus one
// - config bits 7:4 read zero, ignore writes
// - setup field inserts zero to three cycles
// - strobe lasts field plus one cycles
// - hold keeps address zero to three cycles
// - low address on bus while latch high
module emit_timing (
    // clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               sys_rst_i,
    // special-register port
    input  wire logic [7:0]         sfr_addr_i,
    input  wire logic               sfr_wr_i,
    input  wire logic [7:0]         sfr_wdata_i,
    output logic [7:0]              sfr_rdata_o,
    // move requests from the core
    input  wire logic               external_move_instruction_req_i,
    input  wire emit_pkg::emit_req_s external_move_instruction_i,
    input  wire logic               muxed_i,
    output logic                    offchip_o,
    output logic                    busy_o,
    output logic                    done_o,
    output logic [7:0]              rdata_o,
    // external pins
    input  wire logic [7:0]         ad_i,
    output emit_pkg::emit_pins_s    pins_o
);
    typedef struct packed {
        logic [7:0]            page;                  // external_data_space_page_reg
        logic [7:0]            cfg;                   // ext_mem_config_reg
        logic [7:0]            tmg;                   // ext_mem_timing_reg
        emit_pkg::emit_phase_e phase;                 // sequencer phase
        logic                  wr;                    // access is a write
        logic                  mux;                   // access is multiplexed
        logic                  hi_oe;                 // drive upper address nibble
        logic [11:0]           addr;                  // latched effective address
        logic [7:0]            wdata;                 // latched write data
        logic [7:0]            rdata;                 // captured read data
        logic [7:0]            sfr_rd;                // registered read-back
        logic                  done;                  // end-of-access pulse
    } emit_state_s;

    emit_state_s cur;
    emit_state_s next_cur;
    logic        ph_last;                             // counter at phase end
    logic        ph_load;                             // start of a new phase
    logic [4:0]  ph_len;                              // new phase length minus one
    logic        off;                                 // request decodes off-chip
    logic [15:0] eff;                                 // effective request address

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // length in cycles of a phase from the live register values
    function automatic logic [4:0] phase_len(input emit_pkg::emit_phase_e ph,
                                             input logic [7:0] cfg,
                                             input logic [7:0] tmg);
        logic [4:0] len;
        len = 5'h00;
        case (ph)
            emit_pkg::EMIT_ALE_HI,
            emit_pkg::EMIT_ALE_LO: len = {3'b000, cfg[emit_pkg::EMIT_ALE_LSB +: 2]} + 5'h01;
            emit_pkg::EMIT_SETUP:  len = {3'b000, tmg[emit_pkg::EMIT_EAS_LSB +: 2]};
            emit_pkg::EMIT_STROBE: len = {1'b0, tmg[emit_pkg::EMIT_EWR_LSB +: 4]} + 5'h01;
            emit_pkg::EMIT_HOLD:   len = {3'b000, tmg[emit_pkg::EMIT_EAH_LSB +: 2]};
            emit_pkg::EMIT_OVHD:   len = emit_pkg::EMIT_OVHD_CYC;
            default:               len = 5'h00;
        endcase
        return len;
    endfunction

    // fixed phase order; the latch phases only in multiplexed operation
    function automatic emit_pkg::emit_phase_e follow(input emit_pkg::emit_phase_e ph,
                                                     input logic mux);
        emit_pkg::emit_phase_e nx;
        nx = emit_pkg::EMIT_IDLE;
        case (ph)
            emit_pkg::EMIT_IDLE:   nx = mux ? emit_pkg::EMIT_ALE_HI : emit_pkg::EMIT_SETUP;
            emit_pkg::EMIT_ALE_HI: nx = emit_pkg::EMIT_ALE_LO;
            emit_pkg::EMIT_ALE_LO: nx = emit_pkg::EMIT_SETUP;
            emit_pkg::EMIT_SETUP:  nx = emit_pkg::EMIT_STROBE;
            emit_pkg::EMIT_STROBE: nx = emit_pkg::EMIT_HOLD;
            emit_pkg::EMIT_HOLD:   nx = emit_pkg::EMIT_OVHD;
            default:               nx = emit_pkg::EMIT_IDLE;
        endcase
        return nx;
    endfunction

    // ****************************************************************
    // address decode of a request
    // ****************************************************************
    // 8-bit moves take the page as high byte; only the low nibble of it
    // reaches the bus, and only in bank-select mode; the top bit only picks on/off-chip
    always_comb begin
        eff = external_move_instruction_i.is8 ? {cur.page, external_move_instruction_i.addr[7:0]} : external_move_instruction_i.addr;
        case (emit_pkg::emit_mode_e'(cur.cfg[emit_pkg::EMIT_MODE_LSB +: 2]))
            emit_pkg::EMIT_MODE_INT:   off = 1'b0;
            emit_pkg::EMIT_MODE_SPLIT,
            emit_pkg::EMIT_MODE_BANK:  off = external_move_instruction_i.is8 ?
                                             cur.page[emit_pkg::EMIT_PAGE_OFF_BIT] :
                                             (external_move_instruction_i.addr >= emit_pkg::EMIT_ONCHIP_TOP);
            emit_pkg::EMIT_MODE_EXT:   off = 1'b1;
            default:                   off = 1'b0;
        endcase
    end

    assign offchip_o = external_move_instruction_req_i && off;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        emit_pkg::emit_phase_e nx;
        nx       = emit_pkg::EMIT_IDLE;
        next_cur = cur;
        ph_load  = 1'b0;
        ph_len   = 5'h00;
        next_cur.done = 1'b0;
        // register writes mask off unused bits
        if (sfr_wr_i && sfr_addr_i == emit_pkg::EMIT_PAGE_ADDR) begin
            next_cur.page = sfr_wdata_i & emit_pkg::EMIT_PAGE_MASK;
        end
        if (sfr_wr_i && sfr_addr_i == emit_pkg::EMIT_CFG_ADDR) begin
            next_cur.cfg = sfr_wdata_i & emit_pkg::EMIT_CFG_MASK;
        end
        if (sfr_wr_i && sfr_addr_i == emit_pkg::EMIT_TMG_ADDR) begin
            next_cur.tmg = sfr_wdata_i;
        end
        // one-cycle read latency; unmapped addresses read zero
        case (sfr_addr_i)
            emit_pkg::EMIT_PAGE_ADDR: next_cur.sfr_rd = cur.page;
            emit_pkg::EMIT_CFG_ADDR:  next_cur.sfr_rd = cur.cfg;
            emit_pkg::EMIT_TMG_ADDR:  next_cur.sfr_rd = cur.tmg;
            default:                  next_cur.sfr_rd = 8'h00;
        endcase
        // sequencer: a phase ends when its counter reaches zero
        if (cur.phase == emit_pkg::EMIT_IDLE) begin
            if (external_move_instruction_req_i && off) begin
                next_cur.wr    = external_move_instruction_i.wr;
                next_cur.mux   = muxed_i;
                next_cur.addr  = eff[11:0];
                next_cur.wdata = external_move_instruction_i.wdata;
                // upper nibble driven by 16-bit moves and bank-select 8-bit moves
                next_cur.hi_oe = !external_move_instruction_i.is8 ||
                    (cur.cfg[emit_pkg::EMIT_MODE_LSB +: 2] == emit_pkg::EMIT_MODE_BANK);
                nx = follow(cur.phase, muxed_i);
                if (phase_len(nx, cur.cfg, cur.tmg) == 5'h00) begin
                    nx = follow(nx, muxed_i);
                end
                ph_load        = 1'b1;
                next_cur.phase = nx;
            end
        end else if (ph_last) begin
            if (cur.phase == emit_pkg::EMIT_STROBE && !cur.wr) begin
                next_cur.rdata = ad_i;                // sample at the strobe's last cycle
            end
            nx = follow(cur.phase, cur.mux);
            // setup and hold may be zero long; they are never adjacent
            if (nx != emit_pkg::EMIT_IDLE && phase_len(nx, cur.cfg, cur.tmg) == 5'h00) begin
                nx = follow(nx, cur.mux);
            end
            ph_load        = (nx != emit_pkg::EMIT_IDLE);
            next_cur.phase = nx;
            next_cur.done  = (nx == emit_pkg::EMIT_IDLE);
        end
        if (ph_load) begin
            ph_len = phase_len(nx, cur.cfg, cur.tmg) - 5'h01;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cur       <= '0;
            cur.page  <= emit_pkg::EMIT_PAGE_RST;
            cur.cfg   <= emit_pkg::EMIT_CFG_RST;
            cur.tmg   <= emit_pkg::EMIT_TMG_RST;
            cur.phase <= emit_pkg::EMIT_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    emit_phase_cnt u_cnt (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .load_i     (ph_load),
        .load_val_i (ph_len),
        .last_o     (ph_last)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    // low byte sits on the shared bus through both latch phases, then write data on writes
    always_comb begin
        logic act;
        act = (cur.phase != emit_pkg::EMIT_IDLE);
        pins_o.addr       = cur.addr;
        pins_o.addr_hi_oe = act && cur.hi_oe;
        pins_o.addr_lo_oe = act;
        pins_o.ale        = (cur.phase == emit_pkg::EMIT_ALE_HI);
        pins_o.ad         = (cur.phase == emit_pkg::EMIT_ALE_HI ||
                             cur.phase == emit_pkg::EMIT_ALE_LO) ? cur.addr[7:0] : cur.wdata;
        pins_o.ad_oe      = (cur.phase == emit_pkg::EMIT_ALE_HI) ||
                            (cur.phase == emit_pkg::EMIT_ALE_LO) ||
                            (cur.wr && (cur.phase == emit_pkg::EMIT_SETUP ||
                                        cur.phase == emit_pkg::EMIT_STROBE ||
                                        cur.phase == emit_pkg::EMIT_HOLD));
        pins_o.rd_n       = !(cur.phase == emit_pkg::EMIT_STROBE && !cur.wr);
        pins_o.wr_n       = !(cur.phase == emit_pkg::EMIT_STROBE && cur.wr);
    end

    assign busy_o      = (cur.phase != emit_pkg::EMIT_IDLE);
    assign done_o      = cur.done;
    assign rdata_o     = cur.rdata;
    assign sfr_rdata_o = cur.sfr_rd;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking chk_cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [6:0] acc_cyc;                              // cycles of current access
    logic [4:0] ale_run;                              // length of latch high run
    logic [4:0] stb_run;                              // length of strobe run
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !busy_o) begin
            acc_cyc <= 7'h00;
        end else begin
            acc_cyc <= acc_cyc + 7'h01;
        end
        ale_run <= pins_o.ale ? ale_run + 5'h01 : 5'h00;
        stb_run <= (!pins_o.rd_n || !pins_o.wr_n) ? stb_run + 5'h01 : 5'h00;
    end

    sequence strobe_seq;
        $fell(pins_o.rd_n & pins_o.wr_n);
    endsequence
    sequence setup_seq;
        busy_o && pins_o.rd_n && pins_o.wr_n && !pins_o.ale;
    endsequence

    access_len_a: assert property (done_o |-> acc_cyc == 7'(cur.mux ?
        2 * (cur.cfg[1:0] + 1) : 0) + 7'(cur.tmg[7:6]) + 7'(cur.tmg[5:2]) + 7'h01
        + 7'(cur.tmg[1:0]) + 7'(emit_pkg::EMIT_OVHD_CYC))
        else $error("access length not sum plus overhead");
    mux_min_a: assert property (done_o && cur.mux |-> acc_cyc >= 7'd7)
        else $error("multiplexed access shorter than seven cycles");
    ale_width_a: assert property ($fell(pins_o.ale) |->
        ale_run == {3'b000, cur.cfg[1:0]} + 5'h01)
        else $error("latch high width wrong");
    strobe_width_a: assert property ($rose(pins_o.rd_n & pins_o.wr_n) && busy_o |->
        stb_run == {1'b0, cur.tmg[5:2]} + 5'h01)
        else $error("strobe width wrong");
    ale_addr_a: assert property (pins_o.ale |-> pins_o.ad_oe &&
        pins_o.ad == cur.addr[7:0])
        else $error("low address not on bus during latch");
    // the strobe may only open straight after idle, the latch low phase or setup
    order_a: assert property (strobe_seq |->
        $past(cur.phase) != emit_pkg::EMIT_HOLD && $past(cur.phase) != emit_pkg::EMIT_OVHD &&
        $past(cur.phase) != emit_pkg::EMIT_ALE_HI)
        else $error("strobe out of order");
    setup_run_a: assert property (busy_o && $past(!busy_o) && !cur.mux &&
        cur.tmg[7:6] == 2'b11 |-> setup_seq [*3])
        else $error("setup shorter than three cycles");
    page_rb_a: assert property (sfr_addr_i == emit_pkg::EMIT_PAGE_ADDR |=>
        sfr_rdata_o[7:5] == 3'b000)
        else $error("page upper bits not zero");
    cfg_rb_a: assert property (cur.cfg[7:4] == 4'h0 && cur.page[7:5] == 3'b000)
        else $error("unused config bits set");
    rst_val_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        sys_rst_i |=> cur.tmg == emit_pkg::EMIT_TMG_RST &&
        cur.cfg == emit_pkg::EMIT_CFG_RST && cur.page == emit_pkg::EMIT_PAGE_RST)
        else $error("reset values wrong");
    int_only_a: assert property (cur.cfg[3:2] == 2'b00 |-> !offchip_o)
        else $error("internal-only mode went off-chip");
endmodule
`default_nettype wire

/* File: emit_sram_model.sv */
// sram model behind the external memory port, with an address latch for the shared bus
`default_nettype none
module emit_sram_model (
    // clock
    input  wire logic                 core_clk_i,
    // pins from the memory port
    input  wire emit_pkg::emit_pins_s pins_i,
    input  wire logic                 muxed_i,
    // data back toward the port, last strobed address
    output logic [7:0]                ad_o,
    output logic [11:0]               last_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // storage and latch
    // ****************************************************************
    logic [7:0]  mem [0:4095];            // backing store
    logic [7:0]  latch_q = 8'h00;         // external low address latch
    logic [7:0]  last_q  = 8'h00;         // last byte driven back
    logic [11:0] eff_addr;                // address seen by the memory
    // undriven upper lines are taken as zero by this model
    assign eff_addr = {pins_i.addr_hi_oe ? pins_i.addr[11:8] : 4'h0,
                       muxed_i ? latch_q : pins_i.addr[7:0]};
    // released bus shows the inverse of the last byte, never a stale copy
    assign ad_o = !pins_i.rd_n ? mem[eff_addr] : ~last_q;
    // latch follows the bus while ale is high and holds what it had at the fall
    always_ff @(posedge core_clk_i) begin
        if (pins_i.ale) begin
            latch_q <= pins_i.ad;
        end
        if (!pins_i.wr_n) begin
            mem[eff_addr] <= pins_i.ad;
        end
        if (!pins_i.rd_n) begin
            last_q <= ad_o;
        end
        if (!pins_i.wr_n || !pins_i.rd_n) begin
            last_addr_o <= eff_addr;
        end
    end
endmodule
`default_nettype wire

/* File: emit_timing_tb.sv */
// testbench: register port checks and randomised off-chip moves against the sram model
`default_nettype none
module emit_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DLY = 2;               // drive and sample offset after each edge
    logic                 core_clk_i  = 1'b0;
    logic                 sys_rst_i   = 1'b1;
    logic [7:0]           sfr_addr_i  = 8'h00;
    logic                 sfr_wr_i    = 1'b0;
    logic [7:0]           sfr_wdata_i = 8'h00;
    logic                 external_move_instruction_req_i  = 1'b0;
    emit_pkg::emit_req_s  external_move_instruction_i      = '0;
    logic                 muxed_i     = 1'b0;
    logic [7:0]           sfr_rdata_o, rdata_o, ad_i;
    logic                 offchip_o, busy_o, done_o;
    emit_pkg::emit_pins_s pins_o;
    logic [11:0]          last_addr;
    int                   bad_count = 0;
    int                   checked   = 0;
    logic [31:0]          seed      = 32'h000077D9;
    // 25 MHz system clock
    always #20 core_clk_i = ~core_clk_i;
    emit_timing u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .external_move_instruction_req_i(external_move_instruction_req_i), .external_move_instruction_i(external_move_instruction_i), .muxed_i(muxed_i), .offchip_o(offchip_o),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .ad_i(ad_i), .pins_o(pins_o));
    emit_sram_model u_mem (.core_clk_i(core_clk_i), .pins_i(pins_o), .muxed_i(muxed_i),
        .ad_o(ad_i), .last_addr_o(last_addr));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // edges from raising the request until done is seen
    function automatic int exp_len(logic [7:0] cfg, logic [7:0] tmg, logic mux);
        return (mux ? 2 * (int'(cfg[1:0]) + 1) : 0) + int'(tmg[7:6]) + int'(tmg[5:2]) + 1
            + int'(tmg[1:0]) + 4 + 1;
    endfunction
    // upper nibble comes from the page only in bank-select mode
    function automatic logic [11:0] exp_addr(logic [1:0] md, logic is8, logic [7:0] pg,
                                             logic [15:0] a);
        if (!is8) return a[11:0];
        return {(md == 2'b10) ? pg[3:0] : 4'h0, a[7:0]};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #DLY;
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        @(posedge core_clk_i);
        #DLY;
        sfr_wr_i    = 1'b0;
    endtask
    // read-back arrives one cycle after the address is presented
    task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        #DLY;
        sfr_addr_i = a;
        @(posedge core_clk_i);
        #DLY;
        cmp({8'h00, sfr_rdata_o}, {8'h00, exp});
    endtask
    // request held until done, then dropped before the next edge
    task automatic move(input logic wr, input logic is8, input logic [15:0] a,
                        input logic [7:0] d, output int n);
        @(posedge core_clk_i);
        #DLY;
        external_move_instruction_i     = {wr, is8, a, d};
        external_move_instruction_req_i = 1'b1;
        #1;
        cmp({15'h0000, offchip_o}, 16'h0001);
        n = 0;
        while (done_o !== 1'b1 && n < 200) begin
            @(posedge core_clk_i);
            #DLY;
            n++;
        end
        external_move_instruction_req_i = 1'b0;
        cmp({15'h0000, busy_o}, 16'h0000);
    endtask
    // on-chip requests must not claim the port
    task automatic probe(input logic is8, input logic [15:0] a);
        @(posedge core_clk_i);
        #DLY;
        external_move_instruction_i     = {1'b0, is8, a, 8'h00};
        external_move_instruction_req_i = 1'b1;
        #1;
        cmp({15'h0000, offchip_o}, 16'h0000);
        external_move_instruction_req_i = 1'b0;
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************************************
    // watchdog, sized well beyond the longest run
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        end_of_test();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int          n;
        logic [31:0] r;
        logic [1:0]  md;
        logic [7:0]  cfg, tmg, pg, d;
        logic [15:0] a;
        logic        is8, mux;
        repeat (6) @(posedge core_clk_i);
        #DLY;
        sys_rst_i = 1'b0;
        sfr_chk(emit_pkg::EMIT_PAGE_ADDR, 8'h00);
        sfr_chk(emit_pkg::EMIT_CFG_ADDR, 8'h03);
        sfr_chk(emit_pkg::EMIT_TMG_ADDR, 8'hFF);
        probe(1'b0, 16'h1234);
        sfr_wr(emit_pkg::EMIT_PAGE_ADDR, 8'hFF);
        sfr_chk(emit_pkg::EMIT_PAGE_ADDR, 8'h1F);
        sfr_wr(emit_pkg::EMIT_CFG_ADDR, 8'hF4);
        sfr_chk(emit_pkg::EMIT_CFG_ADDR, 8'h04);
        sfr_wr(emit_pkg::EMIT_PAGE_ADDR, 8'h01);
        probe(1'b1, 16'h0055);
        sfr_wr(8'hAC, 8'h5A);
        sfr_chk(8'hAC, 8'h00);
        // random moves; first two use the shortest and longest timing
        for (int i = 0; i < 24; i++) begin
            r   = rnd();
            md  = (r[1:0] == 2'b00) ? 2'b11 : r[1:0];
            cfg = {4'h0, md, r[3:2]};
            tmg = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[11:4];
            mux = (i == 1) ? 1'b0 : r[12];
            is8 = r[13];
            pg  = {3'h0, 1'b1, r[17:14]};
            a   = is8 ? {8'h00, r[25:18]} : {4'h1, r[25:14]};
            d   = r[31:24];
            sfr_wr(emit_pkg::EMIT_PAGE_ADDR, pg);
            sfr_wr(emit_pkg::EMIT_CFG_ADDR, cfg);
            sfr_wr(emit_pkg::EMIT_TMG_ADDR, tmg);
            muxed_i = mux;
            move(1'b1, is8, a, d, n);
            cmp(16'(n), 16'(exp_len(cfg, tmg, mux)));
            cmp({4'h0, last_addr}, {4'h0, exp_addr(md, is8, pg, a)});
            move(1'b0, is8, a, 8'h00, n);
            cmp(16'(n), 16'(exp_len(cfg, tmg, mux)));
            cmp({8'h00, rdata_o}, {8'h00, d});
        end
        // a second reset mid-run must bring the longest timing back
        sys_rst_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #DLY;
        sys_rst_i = 1'b0;
        sfr_chk(emit_pkg::EMIT_TMG_ADDR, 8'hFF);
        sfr_chk(emit_pkg::EMIT_CFG_ADDR, 8'h03);
        end_of_test();
    end
endmodule
`default_nettype wire
